// File: include/phy_retention_pkg.sv
// package: register map, codes and types of the retention and counter block
package phy_retention_pkg;

    // register byte offsets
    localparam logic [9:0] OFS_FEAT     = 10'h000;
    localparam logic [9:0] OFS_STATUS   = 10'h004;
    localparam logic [9:0] OFS_MODES    = 10'h008;
    localparam logic [9:0] OFS_GEOM     = 10'h00c;
    localparam logic [9:0] OFS_LBA_LO   = 10'h010;
    localparam logic [9:0] OFS_LBA_HI   = 10'h014;
    localparam logic [9:0] OFS_SECURITY = 10'h018;
    localparam logic [9:0] OFS_IDENT    = 10'h01c;
    localparam logic [9:0] OFS_LOGCTL   = 10'h020;
    localparam logic [9:0] OFS_STREAM   = 10'h024;
    localparam int         LOG_SEL_BIT  = 9;   // address bit: log page window
    localparam int         LOG_WORDS    = 128; // 512 byte page
    localparam logic [6:0] LOG_LAST     = 7'h7f;

    // set features subcommands
    localparam logic [7:0] SF_WCE_ON    = 8'h02;
    localparam logic [7:0] SF_WCE_OFF   = 8'h82;
    localparam logic [7:0] SF_XFER      = 8'h03;
    localparam logic [7:0] SF_APM_ON    = 8'h05;
    localparam logic [7:0] SF_APM_OFF   = 8'h85;
    localparam logic [7:0] SF_PRESERVE  = 8'h06;
    localparam logic [7:0] SF_DIPM_ON   = 8'h10;
    localparam logic [7:0] SF_DIPM_OFF  = 8'h90;
    localparam logic [7:0] SF_RLA_OFF   = 8'h55;
    localparam logic [7:0] SF_RLA_ON    = 8'haa;
    localparam logic [7:0] SF_REV_ON    = 8'hcc;
    localparam logic [7:0] SF_REV_OFF   = 8'h66;
    localparam logic [7:0] LOG_PHY_PAGE = 8'h11;

    // identify words
    localparam logic [15:0] ID76_VALUE   = 16'h0400; // bit 10: counters
    localparam int          ID79_DIPM    = 3;

    // counter table: width code 1h in bits 14:12, 16-bit counters
    localparam int          CNT_W        = 16;
    localparam int          CNT_TBL      = 4;
    localparam int          CNT_MAND     = 2;
    localparam logic [15:0] CNT_ID [CNT_TBL] = '{
        16'h1001, 16'h100a, 16'h1009, 16'h100b};

    localparam logic [2:0]  UNLOCK_TRIES = 3'h5;
    localparam logic [2:0]  SEC_STATE_PO = 3'h1;
    localparam logic [47:0] MAX_LBA_DEF  = 48'h0000_0fff_ffff;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [9:0]  address;
        logic [31:0] writedata;
    } av_req_s;

    typedef struct packed {
        logic        pres_en;
        logic        dipm_en;
        logic        wce_en;
        logic        apm_en;
        logic        rla_en;
        logic        revert_en;
        logic        sec_frozen;
        logic        san_frozen;
        logic [7:0]  xfer_mode;
        logic [7:0]  apm_level;
        logic [7:0]  mult_size;
        logic [7:0]  stby_timer;
        logic [15:0] geom;
        logic [2:0]  sec_state;
        logic [2:0]  unlock_cnt;
        logic [47:0] max_lba;
        logic [7:0]  rd_err_log;
        logic [7:0]  wr_err_log;
    } cfg_s;

    localparam cfg_s CFG_DEF = '{
        pres_en: 1'b1, dipm_en: 1'b0, wce_en: 1'b1, apm_en: 1'b0,
        rla_en: 1'b1, revert_en: 1'b0, sec_frozen: 1'b0,
        san_frozen: 1'b0, xfer_mode: 8'h00, apm_level: 8'h00,
        mult_size: 8'h00, stby_timer: 8'h00, geom: 16'h0000,
        sec_state: SEC_STATE_PO, unlock_cnt: UNLOCK_TRIES,
        max_lba: MAX_LBA_DEF, rd_err_log: 8'h00, wr_err_log: 8'h00};

endpackage : phy_retention_pkg

// File: core/phy_event_counter.sv
// one saturating phy event counter
`timescale 1ns/1ps
module phy_event_counter #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         clr_i,
    input  wire logic         inc_i,
    output logic      [W-1:0] count_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } cst_s;

    cst_s st_reg;
    cst_s st_next;

    if (W < 2) begin : g_bad_w
        $error("counter width too small");
    end

    ////////////////////////////////////////////////////////////////////
    // event in the same cycle as a clear counts as one, so no event is lost
    always_comb begin
        st_next = st_reg;
        if (clr_i) begin
            st_next.cnt = '0;
        end
        if (inc_i && (clr_i || st_reg.cnt != '1)) begin
            st_next.cnt = clr_i ? W'(1) : st_reg.cnt + W'(1);
        end
    end

    // power-on only: resets of the link leave the count alone
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count_o = st_reg.cnt;

    ////////////////////////////////////////////////////////////////////
    chk_sat_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st_reg.cnt == '1 && !clr_i) |=> st_reg.cnt == '1)
        else $error("counter left its ceiling");

endmodule : phy_event_counter

// File: core/phy_retention.sv
// settings preservation and phy event counters behind an avalon slave
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module phy_retention
    import phy_retention_pkg::*;
#(
    parameter int NUM_CNT = 4
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire phy_retention_pkg::av_req_s av_i,
    output logic                           waitrequest_o,
    output logic                    [31:0] readdata_o,
    input  wire logic                      comreset_i,
    input  wire logic                      soft_rst_i,
    input  wire logic                      bist_i,
    input  wire logic        [NUM_CNT-1:0] evt_i,
    output phy_retention_pkg::cfg_s         cfg_o
);
    import phy_retention_pkg::*;

    typedef struct packed {
        cfg_s        cfg;
        logic        wait_q;
        logic [31:0] rdata;
        logic        clr_armed;
        logic [7:0]  log_page;
        logic [15:0] last_feat;
    } st_s;

    st_s                st_reg;
    st_s                st_next;
    logic [CNT_W-1:0]   cnt_w [NUM_CNT];
    logic               clr_all;
    logic               wr_go;
    logic               rd_go;
    logic [6:0]         word_idx;
    logic [7:0]         sub;
    logic [7:0]         scnt;
    logic [31:0]        rd_val;

    ////////////////////////////////////////////////////////////////////
    // refuse a table the log page or the id list cannot carry
    if (NUM_CNT < CNT_MAND || NUM_CNT > CNT_TBL
        || NUM_CNT > LOG_WORDS - 2) begin : g_bad_cnt
        $error("NUM_CNT out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // counters, one per implemented identifier
    for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
        phy_event_counter #(
            .W       (CNT_W)
        ) u_cnt (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .clr_i   (clr_all),
            .inc_i   (evt_i[g]),
            .count_o (cnt_w[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // bus handshake: request is answered one cycle after it is seen,
    // and takes effect on the edge where waitrequest is low
    assign wr_go    = av_i.write && !st_reg.wait_q;
    assign rd_go    = av_i.read && !st_reg.wait_q;
    assign word_idx = av_i.address[8:2];
    assign sub      = av_i.writedata[7:0];
    assign scnt     = av_i.writedata[15:8];

    // clear after the last word of an armed page read went out
    assign clr_all = bist_i
        || (rd_go && av_i.address[LOG_SEL_BIT]
            && word_idx == LOG_LAST && st_reg.clr_armed);

    ////////////////////////////////////////////////////////////////////
    // read decode; unmapped addresses read as zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (av_i.address[LOG_SEL_BIT]) begin
            // word 0 is the header, then {value, id} per counter,
            // then zero words whose zero id ends the list
            for (int i = 0; i < NUM_CNT; i++) begin
                if (32'(word_idx) == i + 1) begin
                    rd_val = {cnt_w[i], CNT_ID[i]};
                end
            end
        end else begin
            unique case (av_i.address)
                OFS_FEAT:     rd_val = {16'h0000, st_reg.last_feat};
                OFS_STATUS:   rd_val = {24'h000000,
                                        st_reg.cfg.pres_en,
                                        st_reg.cfg.dipm_en,
                                        st_reg.cfg.wce_en,
                                        st_reg.cfg.apm_en,
                                        st_reg.cfg.rla_en,
                                        st_reg.cfg.revert_en,
                                        st_reg.cfg.sec_frozen,
                                        st_reg.cfg.san_frozen};
                OFS_MODES:    rd_val = {8'h00, st_reg.cfg.mult_size,
                                        st_reg.cfg.apm_level,
                                        st_reg.cfg.xfer_mode};
                OFS_GEOM:     rd_val = {8'h00, st_reg.cfg.stby_timer,
                                        st_reg.cfg.geom};
                OFS_LBA_LO:   rd_val = st_reg.cfg.max_lba[31:0];
                OFS_LBA_HI:   rd_val = {16'h0000,
                                        st_reg.cfg.max_lba[47:32]};
                OFS_SECURITY: rd_val = {24'h000000, 1'b0,
                                        st_reg.cfg.unlock_cnt,
                                        1'b0, st_reg.cfg.sec_state};
                OFS_IDENT:    rd_val = {ID76_VALUE, 16'h0000}
                                       | (32'(st_reg.cfg.dipm_en)
                                          << ID79_DIPM);
                OFS_LOGCTL:   rd_val = {23'h000000, st_reg.clr_armed,
                                        st_reg.log_page};
                OFS_STREAM:   rd_val = {16'h0000, st_reg.cfg.wr_err_log,
                                        st_reg.cfg.rd_err_log};
                default:      rd_val = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state: bus writes, then resets, which win over a write
    always_comb begin
        st_next = st_reg;
        st_next.wait_q = !((av_i.read || av_i.write) && st_reg.wait_q);
        if ((av_i.read || av_i.write) && st_reg.wait_q) begin
            st_next.rdata = av_i.read ? rd_val : 32'h0000_0000;
        end
        if (clr_all && !bist_i) begin
            st_next.clr_armed = 1'b0;
        end
        if (wr_go) begin
            unique case (av_i.address)
                OFS_FEAT: begin
                    st_next.last_feat = av_i.writedata[15:0];
                    // subcommands of unsupported features are ignored
                    case (sub)
                        SF_WCE_ON:   st_next.cfg.wce_en = 1'b1;
                        SF_WCE_OFF:  st_next.cfg.wce_en = 1'b0;
                        SF_XFER:     st_next.cfg.xfer_mode = scnt;
                        SF_APM_ON: begin
                            st_next.cfg.apm_en    = 1'b1;
                            st_next.cfg.apm_level = scnt;
                        end
                        SF_APM_OFF:  st_next.cfg.apm_en = 1'b0;
                        SF_PRESERVE: st_next.cfg.pres_en = |scnt;
                        SF_DIPM_ON:  st_next.cfg.dipm_en = 1'b1;
                        SF_DIPM_OFF: st_next.cfg.dipm_en = 1'b0;
                        SF_RLA_ON:   st_next.cfg.rla_en = 1'b1;
                        SF_RLA_OFF:  st_next.cfg.rla_en = 1'b0;
                        SF_REV_ON:   st_next.cfg.revert_en = 1'b1;
                        SF_REV_OFF:  st_next.cfg.revert_en = 1'b0;
                        default:     st_next.cfg = st_reg.cfg;
                    endcase
                end
                OFS_MODES: st_next.cfg.mult_size = av_i.writedata[23:16];
                OFS_GEOM: begin
                    st_next.cfg.geom       = av_i.writedata[15:0];
                    st_next.cfg.stby_timer = av_i.writedata[23:16];
                end
                OFS_LBA_LO: st_next.cfg.max_lba[31:0] = av_i.writedata;
                OFS_LBA_HI:
                    st_next.cfg.max_lba[47:32] = av_i.writedata[15:0];
                OFS_SECURITY: begin
                    // bit0 freeze, bit1 failed unlock, bit2 sanitize
                    // freeze, bit3 loads the state from bits 6:4
                    if (av_i.writedata[0]) begin
                        st_next.cfg.sec_frozen = 1'b1;
                    end
                    if (av_i.writedata[1] && st_reg.cfg.unlock_cnt != '0) begin
                        st_next.cfg.unlock_cnt = st_reg.cfg.unlock_cnt - 3'h1;
                    end
                    if (av_i.writedata[2]) begin
                        st_next.cfg.san_frozen = 1'b1;
                    end
                    if (av_i.writedata[3]) begin
                        st_next.cfg.sec_state = av_i.writedata[6:4];
                    end
                end
                OFS_LOGCTL: begin
                    st_next.log_page  = av_i.writedata[7:0];
                    st_next.clr_armed = av_i.writedata[7:0] == LOG_PHY_PAGE
                                        && av_i.writedata[8];
                end
                OFS_STREAM: begin
                    st_next.cfg.rd_err_log = av_i.writedata[7:0];
                    st_next.cfg.wr_err_log = av_i.writedata[15:8];
                end
                default: st_next.cfg = st_next.cfg;
            endcase
        end
        // comreset: keep the listed settings while preserving; a
        // dropped set returns to defaults, sanitize freeze included; security state, freeze and unlock count never move
        if (comreset_i) begin
            if (st_reg.cfg.pres_en) begin
                st_next.cfg = st_reg.cfg;
            end else begin
                st_next.cfg            = CFG_DEF;
                st_next.cfg.sec_state  = st_reg.cfg.sec_state;
                st_next.cfg.sec_frozen = st_reg.cfg.sec_frozen;
                st_next.cfg.unlock_cnt = st_reg.cfg.unlock_cnt;
            end
            st_next.clr_armed = 1'b0;
        end else if (soft_rst_i && st_reg.cfg.revert_en) begin
            // soft reset keeps settings unless reverting is enabled
            st_next.cfg            = CFG_DEF;
            st_next.cfg.pres_en    = st_reg.cfg.pres_en;
            st_next.cfg.revert_en  = st_reg.cfg.revert_en;
            st_next.cfg.sec_state  = st_reg.cfg.sec_state;
            st_next.cfg.sec_frozen = st_reg.cfg.sec_frozen;
            st_next.cfg.unlock_cnt = st_reg.cfg.unlock_cnt;
            st_next.cfg.max_lba    = st_reg.cfg.max_lba;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power-on state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg           <= '0;
            st_reg.cfg       <= CFG_DEF;
            st_reg.wait_q    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign waitrequest_o = st_reg.wait_q;
    assign readdata_o    = st_reg.rdata;
    assign cfg_o         = st_reg.cfg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_pres_default: assert property (
        $past(rst_i) |-> st_reg.cfg.pres_en)
        else $error("preservation not on after power-on");

    chk_pres_feature: assert property (
        wr_go && av_i.address == OFS_FEAT && sub == SF_PRESERVE
        && !comreset_i && !soft_rst_i
        |=> st_reg.cfg.pres_en == ($past(scnt) != '0))
        else $error("preservation subcommand ignored");

    chk_keep_lba: assert property (
        comreset_i && st_reg.cfg.pres_en
        |=> st_reg.cfg.max_lba == $past(st_reg.cfg.max_lba)
            && st_reg.cfg.wce_en == $past(st_reg.cfg.wce_en)
            && st_reg.cfg.geom == $past(st_reg.cfg.geom))
        else $error("preserved setting lost on comreset");

    // whole settings word, so a field dropped from the keep list shows
    chk_keep_all: assert property (
        comreset_i && st_reg.cfg.pres_en
        |=> st_reg.cfg == $past(st_reg.cfg))
        else $error("preserved settings changed on comreset");

    chk_drop_hard: assert property (
        comreset_i && !st_reg.cfg.pres_en
        |=> st_reg.cfg.wce_en == CFG_DEF.wce_en
            && st_reg.cfg.max_lba == MAX_LBA_DEF)
        else $error("comreset did not act as hard reset");

    chk_sec_stays: assert property (
        comreset_i
        |=> $stable(st_reg.cfg.sec_state) && $stable(st_reg.cfg.unlock_cnt))
        else $error("security state moved on comreset");

    chk_frozen_stays: assert property (
        comreset_i |=> $stable(st_reg.cfg.sec_frozen))
        else $error("security freeze lost on comreset");

    chk_unlock_floor: assert property (
        wr_go && av_i.address == OFS_SECURITY
        && st_reg.cfg.unlock_cnt == '0 |=> st_reg.cfg.unlock_cnt == '0)
        else $error("unlock counter wrapped below zero");

    chk_log_ignore: assert property (
        wr_go && av_i.address[LOG_SEL_BIT] && !comreset_i && !soft_rst_i
        |=> $stable(st_reg.cfg))
        else $error("log page write changed settings");

    chk_bist_clear: assert property (
        bist_i && !evt_i[0] |=> cnt_w[0] == '0)
        else $error("bist did not clear counters");

    chk_log_clear: assert property (
        clr_all && !bist_i && evt_i == '0
        |=> cnt_w[0] == '0 && cnt_w[NUM_CNT-1] == '0)
        else $error("read-clear did not clear");

    chk_disarm: assert property (
        clr_all && !bist_i |=> !st_reg.clr_armed)
        else $error("read-clear still armed after clearing");

    chk_cnt_keep: assert property (
        (comreset_i || soft_rst_i) && !clr_all && !evt_i[0]
        |=> $stable(cnt_w[0]))
        else $error("counter lost on reset");

    chk_ident_bit: assert property (
        st_reg.wait_q ##1 rd_go && av_i.address == OFS_IDENT
        |-> readdata_o[31:16] == ID76_VALUE
            && readdata_o[ID79_DIPM] == st_reg.cfg.dipm_en)
        else $error("identify words wrong");

    chk_wait_once: assert property (
        (av_i.read || av_i.write) && st_reg.wait_q
        |=> !st_reg.wait_q ##1 st_reg.wait_q)
        else $error("waitrequest answer timing wrong");

    cov_pres_comreset: cover property (comreset_i && st_reg.cfg.pres_en);
    cov_bist:          cover property (bist_i && cnt_w[0] != '0);
    cov_log_clear:     cover property (clr_all && !bist_i);
    cov_revert:        cover property (soft_rst_i && st_reg.cfg.revert_en);
    cov_unlock_floor:  cover property (wr_go && st_reg.cfg.unlock_cnt == '0);

endmodule : phy_retention

// File: tb/host_model.sv
// host side partner: issues avalon transfers one at a time
`timescale 1ns/1ps
module host_model
    import phy_retention_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  waitrequest_i,
    input  wire logic           [31:0] readdata_i,
    output phy_retention_pkg::av_req_s av_o,
    output logic                       hung_o
);
    initial begin
        av_o = '0;
        hung_o = 1'b0;
    end

    // hold the request until waitrequest is seen low, bounded wait
    task automatic xfer(input logic w, input logic [9:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        av_o <= '{read: !w, write: w, address: a, writedata: d};
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_i !== 1'b0 && n < 32);
        if (waitrequest_i !== 1'b0) hung_o = 1'b1;
        q = readdata_i;
        // released lines show the inverse, never the stale value
        av_o <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d};
        @(posedge clk_i);
    endtask : xfer
endmodule : host_model

// File: tb/tb.sv
// self-checking bench for the retention and counter block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    failures++; $display("wrong value %s expected %h seen %h", n, e, g); \
    end end
module tb;
    import phy_retention_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        comreset = 1'b0;
    logic        soft_rst = 1'b0;
    logic        bist = 1'b0;
    logic [3:0]  evt = 4'h0;
    logic        wait_req;
    logic [31:0] rdata;
    av_req_s     av;
    cfg_s        cfg;
    int          failures = 0;
    int          total_checks = 0;
    logic [15:0] cnt [4];
    // rows: subcommand, sector count, expected status byte
    logic [23:0] rows [16] = '{24'h1000e8, 24'h8200c8, 24'h0580d8,
        24'h5500d0, 24'hcc00d4, 24'h0345d4, 24'h900094, 24'h0200b4,
        24'h8500a4, 24'haa00ac, 24'h6600a8, 24'h1000e8, 24'hcc00ec,
        24'h06006c, 24'h0601ec, 24'h0533fc};

    phy_retention #(.NUM_CNT(4)) dut (.clk_i(clk), .rst_i(rst), .av_i(av),
        .waitrequest_o(wait_req), .readdata_o(rdata), .comreset_i(comreset),
        .soft_rst_i(soft_rst), .bist_i(bist), .evt_i(evt), .cfg_o(cfg));
    host_model host (.clk_i(clk), .waitrequest_i(wait_req),
        .readdata_i(rdata), .av_o(av), .hung_o());

    initial forever #12.5 clk = ~clk;

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
        if (host.hung_o) begin
            failures++;
            give_verdict();
        end
    endtask : wr

    task rd(input string n, input logic [9:0] a, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0, q);
        if (host.hung_o) begin
            failures++;
            give_verdict();
        end
        `CHK(n, e, q)
    endtask : rd

    // one-cycle pulse on comreset, soft reset, bist
    task pul(input logic [2:0] m);
        {comreset, soft_rst, bist} <= m;
        @(posedge clk);
        {comreset, soft_rst, bist} <= 3'h0;
        @(posedge clk);
    endtask : pul

    // n event pulses; expected counts saturate at all ones
    task ev(input logic [3:0] m, input int n);
        repeat (n) begin
            evt <= m;
            @(posedge clk);
        end
        evt <= 4'h0;
        @(posedge clk);
        foreach (cnt[k]) if (m[k]) cnt[k] = (cnt[k] + n > 65535) ?
            16'hffff : 16'(cnt[k] + n);
    endtask : ev

    task chk_log;
        for (int k = 0; k < 6; k++)
            rd("log word", 10'h200 + 10'(4 * k), (k == 0 || k > 4) ?
                32'h0 : {cnt[k - 1], CNT_ID[k - 1]});
    endtask : chk_log

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (cnt[k]) cnt[k] = 16'h0;
        rd("status", OFS_STATUS, 32'h0000_00a8);
        rd("ident", OFS_IDENT, 32'h0400_0000);
        chk_log();
        $display("test reset done");
        foreach (rows[i]) begin
            wr(OFS_FEAT, {16'h0, rows[i][15:8], rows[i][23:16]});
            rd("status", OFS_STATUS, {24'h0, rows[i][7:0]});
        end
        $display("test set features done");
        wr(OFS_MODES, 32'h0007_0000);
        wr(OFS_GEOM, 32'h0012_3456);
        wr(OFS_LBA_LO, 32'h1234_5678);
        wr(OFS_LBA_HI, 32'h0000_9abc);
        wr(OFS_SECURITY, 32'h0000_005f);
        wr(OFS_STREAM, 32'h0000_a55a);
        wr(10'h204, 32'hffff_ffff);
        ev(4'h1, 3);
        ev(4'h2, 1);
        ev(4'h4, 2);
        ev(4'h8, 65540);
        pul(3'h4);
        rd("status", OFS_STATUS, 32'h0000_00ff);
        rd("modes", OFS_MODES, 32'h0007_3345);
        rd("geom", OFS_GEOM, 32'h0012_3456);
        rd("lba lo", OFS_LBA_LO, 32'h1234_5678);
        rd("lba hi", OFS_LBA_HI, 32'h0000_9abc);
        `CHK("cfg lba", 48'h9abc_1234_5678, cfg.max_lba)
        `CHK("cfg san", 1'b1, cfg.san_frozen)
        rd("security", OFS_SECURITY, 32'h0000_0045);
        rd("stream", OFS_STREAM, 32'h0000_a55a);
        rd("ident", OFS_IDENT, 32'h0400_0008);
        chk_log();
        $display("test comreset kept done");
        pul(3'h2);
        rd("status", OFS_STATUS, 32'h0000_00ae);
        chk_log();
        wr(OFS_FEAT, {24'h0, SF_PRESERVE});
        pul(3'h4);
        rd("status", OFS_STATUS, 32'h0000_00aa);
        rd("security", OFS_SECURITY, 32'h0000_0045);
        rd("geom", OFS_GEOM, 32'h0);
        rd("lba lo", OFS_LBA_LO, 32'h0fff_ffff);
        // failed unlocks stop at zero; soft reset without revert keeps all
        repeat (5) wr(OFS_SECURITY, 32'h0000_0002);
        rd("security", OFS_SECURITY, 32'h0000_0005);
        pul(3'h2);
        rd("status", OFS_STATUS, 32'h0000_00aa);
        $display("test preservation off done");
        pul(3'h1);
        foreach (cnt[k]) cnt[k] = 16'h0;
        chk_log();
        ev(4'h1, 5);
        wr(OFS_LOGCTL, 32'h0000_0111);
        rd("logctl", OFS_LOGCTL, 32'h0000_0111);
        chk_log();
        rd("log end", 10'h3fc, 32'h0);
        cnt[0] = 16'h0;
        chk_log();
        rd("unmapped", 10'h030, 32'h0);
        $display("test counter clears done");
        ev(4'h2, 2);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cnt[1] = 16'h0;
        rd("status", OFS_STATUS, 32'h0000_00a8);
        `CHK("cfg", CFG_DEF, cfg)
        chk_log();
        $display("test power cycle done");
        give_verdict();
    end
endmodule : tb
